// >>> hdl/sec_core.sv
/*
  Command core of a 1024 x 8 serial EEPROM behind an SPI slave port.
  Assumes the serial clock runs well below a quarter of i_mclk, since the
  pins are sampled through two flops and edges are found from the samples.
*/

`default_nettype none

module sec_core #(
  parameter int P_WRITE_CYCLES = sec_pkg::WRITE_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // serial port pins
  input wire logic i_cs_b,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // protection pin and supply monitor
  input wire logic i_protect_b,
  input wire logic i_supply_low
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [sec_pkg::PIN_W-1:0] pin_q;
  logic [sec_pkg::PIN_W-1:0] pin_q_d;
  logic cs_b_s;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic si_s;
  logic protect_b_s;
  logic supply_low_s;

  sec_sync #(
    .W(sec_pkg::PIN_W),
    .RST_VAL(sec_pkg::PIN_RST)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_d({i_supply_low, i_protect_b, i_si, i_sck, i_cs_b}),
    .o_q(pin_q),
    .o_q_d(pin_q_d)
  );

  // edges are taken from the second and third stages only
  assign cs_b_s = pin_q[0];
  assign cs_rise = pin_q[0] & ~pin_q_d[0];
  assign sck_rise = pin_q[1] & ~pin_q_d[1];
  assign sck_fall = ~pin_q[1] & pin_q_d[1];
  assign si_s = pin_q[2];
  assign protect_b_s = pin_q[3];
  assign supply_low_s = pin_q[4];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // guard field to protected test for a ten-bit address
  function automatic logic addr_guarded(input logic [1:0] guard,
                                        input logic [sec_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (guard)
      2'b01: hit = (a >= sec_pkg::GUARD_QUARTER_BASE);
      2'b10: hit = (a >= sec_pkg::GUARD_HALF_BASE);
      2'b11: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // live status byte; stored bits only change when a cycle completes
  // status field positions
  function automatic logic [7:0] status_byte(input sec_pkg::sec_core_t s);
    logic [7:0] v;
    v = 8'h00;
    v[sec_pkg::BIT_LOCK] = s.lock;
    v[sec_pkg::BIT_GUARD_HI] = s.guard[1];
    v[sec_pkg::BIT_GUARD_LO] = s.guard[0];
    v[sec_pkg::BIT_LATCH] = s.latch;
    v[sec_pkg::BIT_BUSY] = s.busy;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage arrays

  logic [7:0] mem [sec_pkg::MEM_BYTES];
  logic [7:0] pbuf [sec_pkg::PAGE_BYTES];

  initial begin
    for (int i = 0; i < sec_pkg::MEM_BYTES; i++) begin
      mem[i] = sec_pkg::ERASED_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and next state

  sec_pkg::sec_core_t r;
  sec_pkg::sec_core_t n;
  logic [7:0] sbyte;
  logic hw_lock;
  logic last_cycle;
  logic pb_we;
  logic [sec_pkg::PAGE_W-1:0] pb_idx;
  logic mem_we;
  logic [sec_pkg::ADDR_W-1:0] mem_idx;
  logic [sec_pkg::ADDR_W-1:0] rd_addr;

  assign sbyte = {r.sh[6:0], si_s};
  // lock bit with protect pin low
  assign hw_lock = r.lock & ~protect_b_s;
  assign last_cycle = (r.wcnt == sec_pkg::WCNT_W'(P_WRITE_CYCLES - 1));
  assign mem_idx = {r.addr[sec_pkg::ADDR_W-1:sec_pkg::PAGE_W], r.wcnt[sec_pkg::PAGE_W-1:0]};

  // next-state logic: write cycle first, then the serial frame, droop last
  always_comb begin
    n = r;
    pb_we = 1'b0;
    pb_idx = r.addr[sec_pkg::PAGE_W-1:0];
    mem_we = 1'b0;
    rd_addr = r.addr;

    // busy held for the whole cycle count
    if (r.busy) begin
      n.wcnt = r.wcnt + 1'b1;
      // page commit runs one byte per clock at the start of the cycle
      if (!r.wstat && (r.wcnt[sec_pkg::WCNT_W-1:sec_pkg::PAGE_W] == '0)) begin
        mem_we = r.pvalid[r.wcnt[sec_pkg::PAGE_W-1:0]];
      end
      if (last_cycle) begin
        n.busy = 1'b0;
        n.wcnt = '0;
        n.latch = 1'b0;
        // new stored bits appear only now
        if (r.wstat) begin
          n.lock = r.nv_new[2];
          n.guard = r.nv_new[1:0];
        end
      end
    end

    if (cs_b_s) begin
      // deselect: act on a properly terminated command, then go idle
      if (cs_rise) begin
        case (r.st)
          sec_pkg::ST_ARM: begin
            // set latch after exactly 8 clocks
            // clear latch after exactly 8 clocks
            n.latch = r.arm_set;
          end
          sec_pkg::ST_SARM: begin
            // status write cycle starts at deselect
            n.busy = 1'b1;
            n.wstat = 1'b1;
            n.wcnt = '0;
          end
          sec_pkg::ST_WDATA: begin
            // only whole data bytes start the write
            if (r.bits == 3'd0 && r.have_data) begin
              n.busy = 1'b1;
              n.wstat = 1'b0;
              n.wcnt = '0;
            end
          end
          default: begin
          end
        endcase
      end
      n.st = sec_pkg::ST_OPC;
      n.bits = 3'd0;
      n.abyte = 1'b0;
      n.so_oe = 1'b0;
    end else if (sck_rise) begin
      // input sampled on rising serial clock
      n.sh = sbyte;
      n.bits = r.bits + 3'd1;
      case (r.st)
        sec_pkg::ST_OPC: begin
          // first eight bits are the instruction
          if (r.bits == 3'd7) begin
            case (sbyte)
              sec_pkg::OPC_SET_LATCH: begin
                n.st = sec_pkg::ST_ARM;
                n.arm_set = 1'b1;
              end
              sec_pkg::OPC_CLR_LATCH: begin
                n.st = sec_pkg::ST_ARM;
                n.arm_set = 1'b0;
              end
              sec_pkg::OPC_STAT_READ: begin
                // status read allowed even while busy
                n.st = sec_pkg::ST_SOUT;
                n.osh = status_byte(r);
              end
              sec_pkg::OPC_STAT_WRITE: begin
                if (r.latch && !r.busy && !hw_lock) begin
                  n.st = sec_pkg::ST_SIN;
                end else begin
                  n.st = sec_pkg::ST_IGNORE;
                end
              end
              sec_pkg::OPC_MEM_READ: begin
                n.st = r.busy ? sec_pkg::ST_IGNORE : sec_pkg::ST_ADDR;
                n.is_read = 1'b1;
              end
              sec_pkg::OPC_MEM_WRITE: begin
                // latch needed and no cycle running
                // a refused write must not disturb a page commit in progress
                n.is_read = 1'b0;
                if (r.latch && !r.busy) begin
                  n.st = sec_pkg::ST_ADDR;
                  n.pvalid = '0;
                  n.have_data = 1'b0;
                end else begin
                  n.st = sec_pkg::ST_IGNORE;
                end
              end
              default: begin
                // unknown code ignores the rest of the frame
                n.st = sec_pkg::ST_IGNORE;
              end
            endcase
          end
        end
        sec_pkg::ST_ARM, sec_pkg::ST_SARM: begin
          // extra clocks cancel the pending command
          n.st = sec_pkg::ST_IGNORE;
        end
        sec_pkg::ST_ADDR: begin
          // sixteen address bits follow the code
          if (r.bits == 3'd7) begin
            if (!r.abyte) begin
              n.abyte = 1'b1;
              // only the low two bits of the high byte are kept
              n.addr[9:8] = sbyte[1:0];
            end else begin
              n.addr[7:0] = sbyte;
              rd_addr = {r.addr[9:8], sbyte};
              if (r.is_read) begin
                n.st = sec_pkg::ST_READ;
                n.osh = mem[rd_addr];
              end else if (addr_guarded(r.guard, rd_addr)) begin
                n.st = sec_pkg::ST_IGNORE;
              end else begin
                n.st = sec_pkg::ST_WDATA;
              end
            end
          end
        end
        sec_pkg::ST_WDATA: begin
          if (r.bits == 3'd7) begin
            // low five address bits wrap inside the page
            pb_we = 1'b1;
            n.pvalid[pb_idx] = 1'b1;
            n.addr[sec_pkg::PAGE_W-1:0] = pb_idx + 1'b1;
            n.have_data = 1'b1;
          end
        end
        sec_pkg::ST_SIN: begin
          if (r.bits == 3'd7) begin
            n.nv_new = {sbyte[sec_pkg::BIT_LOCK], sbyte[sec_pkg::BIT_GUARD_HI],
                        sbyte[sec_pkg::BIT_GUARD_LO]};
            n.st = sec_pkg::ST_SARM;
          end
        end
        sec_pkg::ST_READ: begin
          // next byte with wrap at the top
          if (r.bits == 3'd7) begin
            rd_addr = r.addr + 1'b1;
            n.addr = rd_addr;
            n.osh = mem[rd_addr];
          end
        end
        sec_pkg::ST_SOUT: begin
          if (r.bits == 3'd7) begin
            n.osh = status_byte(n);
          end
        end
        default: begin
        end
      endcase
    end else if (sck_fall && (r.st == sec_pkg::ST_READ || r.st == sec_pkg::ST_SOUT)) begin
      // output changes on falling serial clock
      n.so = r.osh[7];
      n.osh = {r.osh[6:0], 1'b0};
      n.so_oe = 1'b1;
    end

    // droop clears the latch and aborts any write
    if (supply_low_s) begin
      n.latch = 1'b0;
      n.busy = 1'b0;
      n.wcnt = '0;
      n.so_oe = 1'b0;
      if (!cs_b_s) begin
        n.st = sec_pkg::ST_IGNORE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // power-on is modelled by reset: latch clear, stored bits at delivered values
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
      r.st <= sec_pkg::ST_OPC;
      r.lock <= sec_pkg::RST_LOCK;
      r.guard <= sec_pkg::RST_GUARD;
    end else begin
      r <= n;
    end
  end

  // page buffer fills during the frame and is copied into the array by the commit
  always_ff @(posedge i_mclk) begin
    if (pb_we) begin
      pbuf[pb_idx] <= sbyte;
    end
  end

  // array writes only happen inside a running cycle
  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      mem[mem_idx] <= pbuf[r.wcnt[sec_pkg::PAGE_W-1:0]];
    end
  end

  // pins driven straight from the state register
  assign o_so = r.so;
  assign o_so_oe = r.so_oe;

endmodule // sec_core

`default_nettype wire

// >>> hdl/sec_pkg.sv
/*
  Package of shared constants and types for the serial EEPROM command core,
  plus the small input synchroniser that the core instantiates.
  Assumes a single free-running master clock; all pins are asynchronous to it.
*/

`default_nettype none

package sec_pkg;
  // array geometry
  localparam int MEM_BYTES = 1024;
  localparam int ADDR_W = 10;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  // instruction codes
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
  localparam logic [7:0] OPC_STAT_READ = 8'h05;
  localparam logic [7:0] OPC_STAT_WRITE = 8'h01;
  localparam logic [7:0] OPC_MEM_READ = 8'h03;
  localparam logic [7:0] OPC_MEM_WRITE = 8'h02;
  // status field positions
  localparam int BIT_LOCK = 7;
  localparam int BIT_GUARD_HI = 3;
  localparam int BIT_GUARD_LO = 2;
  localparam int BIT_LATCH = 1;
  localparam int BIT_BUSY = 0;
  // delivered and reset values
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic RST_LOCK = 1'b0;
  localparam logic [1:0] RST_GUARD = 2'b00;
  // guarded region bases
  localparam logic [9:0] GUARD_QUARTER_BASE = 10'h300;
  localparam logic [9:0] GUARD_HALF_BASE = 10'h200;
  // write cycle timing
  localparam int CELL_PROGRAM_TIME_US = 4000;
  localparam int MCLK_KHZ = 40000;
  localparam int WRITE_CYCLES = CELL_PROGRAM_TIME_US * MCLK_KHZ / 1000;
  localparam int WCNT_W = 18;
  // synchroniser lane order and reset levels (select idles high)
  localparam int PIN_W = 5;
  localparam logic [4:0] PIN_RST = 5'h01;

  typedef enum logic [3:0] {
    ST_OPC, ST_ARM, ST_ADDR, ST_WDATA, ST_SIN, ST_SARM, ST_READ, ST_SOUT, ST_IGNORE
  } sec_state_t;

  typedef struct packed {
    sec_state_t st;
    logic [7:0] sh;
    logic [2:0] bits;
    logic abyte;
    logic is_read;
    logic arm_set;
    logic [ADDR_W-1:0] addr;
    logic [7:0] osh;
    logic so;
    logic so_oe;
    logic latch;
    logic busy;
    logic wstat;
    logic lock;
    logic [1:0] guard;
    logic [2:0] nv_new;
    logic have_data;
    logic [PAGE_BYTES-1:0] pvalid;
    logic [WCNT_W-1:0] wcnt;
  } sec_core_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

// two-flop synchroniser with a third stage for edge detection
module sec_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // asynchronous inputs
  input wire logic [W-1:0] i_d,
  // synchronised level and its one-cycle delayed copy
  output logic [W-1:0] o_q,
  output logic [W-1:0] o_q_d
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= RST_VAL;
      o_q <= RST_VAL;
      o_q_d <= RST_VAL;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
      o_q_d <= o_q;
    end
  end
endmodule // sec_sync

`default_nettype wire

// >>> sim/sec_core_assertions.sv
/*
  Checker on the pins of the serial EEPROM command core.
  Assumes sck idles low and cs_b stays high between frames.
*/
`default_nettype none

module sec_core_assertions #(
  parameter int P_WRITE_CYCLES = 64
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // serial pins
  input wire logic i_cs_b,
  input wire logic i_sck,
  input wire logic o_so,
  input wire logic o_so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // deselect means undriven
  a_oe_idle_off: assert property (i_cs_b [*6] |-> !o_so_oe)
    else $error("serial output driven while deselected");
  // read ends at deselect, sync delay allowed
  a_oe_release: assert property ($rose(i_cs_b) |-> ##[1:5] !o_so_oe)
    else $error("serial output not released after deselect");
  a_oe_hold: assert property (o_so_oe && !i_cs_b |=> o_so_oe)
    else $error("serial output dropped while selected");
  // output moves only after sck falls
  a_so_on_fall: assert property ((o_so_oe && $stable(i_sck)) [*5] |-> $stable(o_so))
    else $error("serial output changed with sck still");
  a_oe_cs_fall: assert property ($fell(i_cs_b) |-> !o_so_oe ##1 !o_so_oe)
    else $error("serial output driven at frame start");
  // drive only deep inside a frame
  a_oe_rise_sel: assert property ($rose(o_so_oe) |-> !i_cs_b && !$past(i_cs_b, 8))
    else $error("serial output enabled outside a frame");
  a_oe_after_fall: assert property ($rose(o_so_oe) |->
    $past(i_sck, 4) || $past(i_sck, 5) || $past(i_sck, 6))
    else $error("serial output enabled away from an sck fall");
  a_reset_quiet: assert property ($rose(i_rst_b) |-> !o_so_oe && !o_so)
    else $error("serial output active at reset release");
endmodule // sec_core_assertions

bind sec_core sec_core_assertions #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) i_sec_core_assertions (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_sck(i_sck),
  .o_so(o_so), .o_so_oe(o_so_oe));

`default_nettype wire

// >>> sim/sec_spi_host.sv
/*
  Host model that drives select, clock and data toward the device.
  Assumes its caller steps it from the falling master clock edge.
*/
`default_nettype none

module sec_spi_host (
  // master clock
  input wire logic i_mclk,
  // pins toward the device
  output logic o_cs_b,
  output logic o_sck,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic oe_seen;

  // idle pins: deselected, clock parked low
  initial begin
    o_cs_b = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b1;
    oe_seen = 1'b0;
  end
  task automatic half(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic sel();
    o_cs_b = 1'b0;
    oe_seen = 1'b0;
    half(2);
  endtask
  // deselect after the last low phase
  task automatic desel();
    half(4);
    o_cs_b = 1'b1;
    o_si = ~o_si; // stale data never lingers
    half(8);
  endtask
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_si = tx[i];
      half(4);
      o_sck = 1'b1;
      half(4);
      rx = {rx[6:0], i_so_oe ? i_so : 1'bx}; // sampled late in the high phase
      oe_seen = oe_seen | i_so_oe;
      o_sck = 1'b0;
    end
  endtask
endmodule // sec_spi_host

`default_nettype wire

// >>> sim/test_spi_eeprom_command_core.sv
/*
  Self-checking bench for the serial EEPROM command core.
  Assumes the host model and a shortened write cycle.
*/
`default_nettype none

module test_spi_eeprom_command_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WCYC = 1000; // long enough to poll status while busy
  localparam logic [7:0] BAD [3] = '{8'h00, 8'h07, 8'hFF};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic prot_b = 1'b1;
  logic sup_low = 1'b0;
  wire cs_b, sck, si, so, so_oe;
  int fails = 0;
  int compares = 0;
  logic [7:0] r[$];
  logic [7:0] q[$];

  always #12.5 mclk = ~mclk;
  sec_core #(.P_WRITE_CYCLES(WCYC)) i_sec_core (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_sck(sck), .i_si(si),
    .o_so(so), .o_so_oe(so_oe), .i_protect_b(prot_b), .i_supply_low(sup_low));
  sec_spi_host i_sec_spi_host (
    .i_mclk(mclk), .o_cs_b(cs_b), .o_sck(sck), .o_si(si), .i_so(so), .i_so_oe(so_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rst();
    rst_b = 1'b0;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    repeat (5) @(negedge mclk);
  endtask
  // one frame of whole bytes plus optional stray clocks
  task automatic frame(input logic [7:0] qi[$], input int extra);
    logic [7:0] b;
    r = {};
    i_sec_spi_host.sel();
    foreach (qi[i]) begin
      i_sec_spi_host.bits(qi[i], 8, b);
      r.push_back(b);
    end
    if (extra > 0) i_sec_spi_host.bits(8'hA5, extra, b);
    i_sec_spi_host.desel();
  endtask
  task automatic sr(input logic [7:0] e);
    frame({8'h05, 8'h00, 8'h00}, 0);
    chk(r[1], e);
    chk(r[2], e);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    frame({8'h03, a[15:8], a[7:0], 8'h00, 8'h00}, 0);
    chk(r[3], e0);
    chk(r[4], e1);
  endtask
  task automatic en();
    frame({8'h06}, 0);
  endtask
  task automatic wt();
    repeat (WCYC) @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst();
    sr(8'h00);
    foreach (BAD[i]) begin
      frame({BAD[i], 8'h00}, 0);
      chk({7'h00, i_sec_spi_host.oe_seen}, 8'h00);
    end
    // latch handling; the refused target lies outside later pages
    frame({8'h02, 8'h01, 8'h00, 8'h55}, 0);
    sr(8'h00);
    frame({8'h06}, 1);
    sr(8'h00);
    en();
    sr(8'h02);
    frame({8'h04}, 1);
    sr(8'h02);
    frame({8'h04}, 0);
    sr(8'h00);
    en();
    q = {8'h02, 8'h00, 8'h00};
    for (int k = 0; k < 33; k++)
      q.push_back(8'(k));
    frame(q, 0);
    wt();
    rd(16'h0000, 8'h20, 8'h01);
    rd(16'h0010, 8'h10, 8'h11);
    en();
    frame({8'h02, 8'hFF, 8'hFE, 8'hA1, 8'hB2, 8'hC3}, 0);
    sr(8'h03);
    frame({8'h03, 8'h00, 8'h00, 8'h00}, 0);
    chk({7'h00, i_sec_spi_host.oe_seen}, 8'h00);
    wt();
    sr(8'h00);
    rd(16'hFFFE, 8'hA1, 8'hB2);
    rd(16'h03FF, 8'hB2, 8'h20);
    rd(16'h03E0, 8'hC3, 8'hFF);
    rd(16'h0100, 8'hFF, 8'hFF);
    en();
    frame({8'h02, 8'h00, 8'h80}, 4);
    sr(8'h02);
    frame({8'h02, 8'h00, 8'h80}, 0);
    sr(8'h02);
    frame({8'h01, 8'h8C}, 0);
    sr(8'h03);
    wt();
    sr(8'h8C);
    en();
    frame({8'h02, 8'h01, 8'h00, 8'h66}, 0);
    sr(8'h8E);
    prot_b = 1'b0;
    frame({8'h01, 8'h00}, 0);
    sr(8'h8E);
    prot_b = 1'b1;
    frame({8'h01, 8'h84}, 0);
    wt();
    sr(8'h84);
    en();
    frame({8'h02, 8'h02, 8'hFF, 8'h5A}, 0);
    sr(8'h87);
    wt();
    en();
    frame({8'h02, 8'h03, 8'h00, 8'h5A}, 0);
    sr(8'h86);
    rd(16'h02FF, 8'h5A, 8'hFF);
    sup_low = 1'b1;
    repeat (4) @(negedge mclk);
    sup_low = 1'b0;
    sr(8'h84);
    rst();
    sr(8'h00);
    finish_test();
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    finish_test();
  end
endmodule // test_spi_eeprom_command_core

`default_nettype wire
